// file: tpwm2_timer.v
// triggered pwm timer: counter, compares, input filters, axi4-lite registers
// assumes inputs synchronous to aclk; pins are resolved by the surroundings
// Function
// - polarity bits set active level, plain pwm
// - control two bits 3 and 4 read one
// - stop bit halts count on period match
// - stop bit only in compare, pwm, triggered_pwm_mode
// - edge field: off, rising, falling, both
// - trigger edge honoured only in triggered_pwm_mode
// - filter enable bits route input through filter
// - channel filters apply to input capture
// - trigger filter only when triggered_pwm_mode trigger on
// - filter clock: f32, f8, f1, count source
// - filter register bit 5 reads zero
// - period compare sets period, out on b
// - change point compare sets level change
// - wait compare sets delay before pulse
// - buffered next change loads change point
// - unbuffered next change unused in triggered_pwm_mode
// - level select b sets idle and active
// - clear select clears counter on period
`timescale 1ns/100ps
`include "tpwm2_defines.vh"
module tpwm2_timer (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // pins
    input  wire [3:0]  timer_pin_in,
    input  wire        external_trigger_pin,
    input  wire        ext_count_clk,
    output reg  [2:0]  timer_pin_bcd_out,
    output reg  [2:0]  timer_pin_bcd_oe
);
    reg  [7:0]  mode_reg;
    reg  [7:0]  timer_control_one_reg;
    reg  [7:0]  triggered_pwm_mode_control_two_reg;
    reg  [7:0]  input_filter_select_reg;
    reg  [15:0] period_compare_reg;
    reg  [15:0] change_point_compare_reg;
    reg  [15:0] wait_time_compare_reg;
    reg  [15:0] next_change_buffer_reg;
    reg  [15:0] main_counter_reg;
    reg  [4:0]  prescale_reg;
    reg         ext_clk_prev_reg;
    reg         halted_reg;
    reg         trig_seen_reg;
    reg         trig_prev_reg;
    reg         aw_held_reg;
    reg  [9:0]  aw_idx_reg;
    reg         w_held_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg  [15:0] cnt_next;
    reg  [31:0] rd_word;
    reg         rd_hit;
    wire [4:0]  pin_raw;
    wire [4:0]  pin_eff;
    wire [4:0]  filt_on;
    wire [1:0]  mode_sel;
    wire [1:0]  edge_sel;
    wire        trig_on;
    wire        stop_eff;
    wire        count_tick;
    wire        filt_tick;
    wire        run;
    wire        trig_edge;
    wire        period_hit;
    wire        wr_go;
    wire        wr_hit;
    wire [9:0]  ar_idx;

    // prescaler tick for a count source code, shared by counter and filters
    function prescale_tick;
        input [2:0] code;
        input [4:0] pre;
        begin
            case (code)
                `TPWM2_CS_F2:  prescale_tick = pre[0];
                `TPWM2_CS_F4:  prescale_tick = &pre[1:0];
                `TPWM2_CS_F8:  prescale_tick = &pre[2:0];
                `TPWM2_CS_F32: prescale_tick = &pre;
                default:       prescale_tick = 1'b1;
            endcase
        end
    endfunction

    // merge a byte-laned write into a register of up to 16 bits
    function [15:0] lane_merge;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            lane_merge[7:0]  = strb[0] ? data[7:0] : old[7:0];
            lane_merge[15:8] = strb[1] ? data[15:8] : old[15:8];
        end
    endfunction

    assign mode_sel = mode_reg[`TPWM2_MODE_HI:`TPWM2_MODE_LO];
    assign edge_sel = triggered_pwm_mode_control_two_reg[`TPWM2_EDGE_HI:`TPWM2_EDGE_LO];
    assign trig_on  = (mode_sel == `TPWM2_MD_TRIGGERED_PWM_MODE) && (edge_sel != `TPWM2_EDGE_OFF);
    assign stop_eff = triggered_pwm_mode_control_two_reg[`TPWM2_STOP_ON_PERIOD_MATCH_BIT] && (mode_sel != `TPWM2_MD_CAPTURE);

    // external count clock is taken on its rising edge, f2 to f32 from the prescaler, other codes tick every cycle
    assign count_tick = (timer_control_one_reg[`TPWM2_CSRC_HI:`TPWM2_CSRC_LO] == `TPWM2_CS_EXT) ?
                        (ext_count_clk && !ext_clk_prev_reg) :
                        prescale_tick(timer_control_one_reg[`TPWM2_CSRC_HI:`TPWM2_CSRC_LO], prescale_reg);

    // filter sampling clock
    assign filt_tick = (input_filter_select_reg[`TPWM2_FCK_HI:`TPWM2_FCK_LO] == `TPWM2_FCK_F32) ?
                       prescale_tick(`TPWM2_CS_F32, prescale_reg) :
                       (input_filter_select_reg[`TPWM2_FCK_HI:`TPWM2_FCK_LO] == `TPWM2_FCK_F8) ?
                       prescale_tick(`TPWM2_CS_F8, prescale_reg) :
                       (input_filter_select_reg[`TPWM2_FCK_HI:`TPWM2_FCK_LO] == `TPWM2_FCK_F1) ?
                       1'b1 : count_tick;

    assign pin_raw = {external_trigger_pin, timer_pin_in};
    assign filt_on[3:0] = (mode_sel == `TPWM2_MD_CAPTURE) ? input_filter_select_reg[3:0] : 4'h0;
    assign filt_on[4]   = trig_on && input_filter_select_reg[`TPWM2_FEN_HI];

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_filt
            reg [`TPWM2_FILT_LEN-1:0] samp_reg;
            reg                       lvl_reg;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    samp_reg <= {`TPWM2_FILT_LEN{1'b0}};
                    lvl_reg  <= 1'b0;
                end else if (filt_tick) begin
                    samp_reg <= {samp_reg[`TPWM2_FILT_LEN-2:0], pin_raw[gi]};
                    // a level passes only once every sample agrees
                    if (&samp_reg)
                        lvl_reg <= 1'b1;
                    else if (~|samp_reg)
                        lvl_reg <= 1'b0;
                end
            end
            assign pin_eff[gi] = filt_on[gi] ? lvl_reg : pin_raw[gi];
        end
    endgenerate

    // trigger edge detect
    assign trig_edge = trig_on &&
                       (((edge_sel[0]) && pin_eff[4] && !trig_prev_reg) ||
                        ((edge_sel[1]) && !pin_eff[4] && trig_prev_reg));

    assign run        = mode_reg[`TPWM2_START_BIT] && !halted_reg && (!trig_on || trig_seen_reg);
    assign period_hit = run && count_tick && (main_counter_reg == period_compare_reg);

    // axi4-lite handshakes: address and data may arrive in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go  = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_hit = (aw_idx_reg == `TPWM2_IDX_MODE) || (aw_idx_reg == `TPWM2_IDX_CTRL1) ||
                    (aw_idx_reg == `TPWM2_IDX_CTRL2) || (aw_idx_reg == `TPWM2_IDX_FILT) ||
                    ((aw_idx_reg >= `TPWM2_IDX_PERIOD) && (aw_idx_reg <= `TPWM2_IDX_COUNT));
    assign ar_idx = s_axi_araddr[11:2];

    always @* begin
        cnt_next = main_counter_reg;
        if (trig_edge)
            cnt_next = `TPWM2_RST16;
        else if (run && count_tick) begin
            if (period_hit && timer_control_one_reg[`TPWM2_COUNTER_CLEAR_SEL_BIT])
                cnt_next = `TPWM2_RST16;
            else
                cnt_next = main_counter_reg + 16'h0001;
        end
    end

    always @* begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (ar_idx == `TPWM2_IDX_MODE)
            rd_word[7:0] = mode_reg;
        else if (ar_idx == `TPWM2_IDX_CTRL1)
            rd_word[7:0] = timer_control_one_reg;
        else if (ar_idx == `TPWM2_IDX_CTRL2)
            rd_word[7:0] = {triggered_pwm_mode_control_two_reg[7:5], `TPWM2_CTRL2_FILL, triggered_pwm_mode_control_two_reg[2:0]};
        else if (ar_idx == `TPWM2_IDX_FILT)
            rd_word[7:0] = {input_filter_select_reg[7:6], 1'b0, input_filter_select_reg[4:0]};
        else if (ar_idx == `TPWM2_IDX_PERIOD)
            rd_word[15:0] = period_compare_reg;
        else if (ar_idx == `TPWM2_IDX_CHANGE)
            rd_word[15:0] = change_point_compare_reg;
        else if (ar_idx == `TPWM2_IDX_WAIT)
            rd_word[15:0] = wait_time_compare_reg;
        else if (ar_idx == `TPWM2_IDX_NEXT)
            rd_word[15:0] = next_change_buffer_reg;
        else if (ar_idx == `TPWM2_IDX_COUNT)
            rd_word[15:0] = main_counter_reg;
        else if (ar_idx == `TPWM2_IDX_STATUS)
            rd_word[7:0] = {run, halted_reg, 1'b0, pin_eff};
        else
            rd_hit = 1'b0;
    end

    // bus slave
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg  <= 1'b0;
            aw_idx_reg   <= 10'h000;
            w_held_reg   <= 1'b0;
            w_data_reg   <= 32'h0000_0000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TPWM2_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `TPWM2_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_idx_reg  <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `TPWM2_OKAY : `TPWM2_SLVERR;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? `TPWM2_OKAY : `TPWM2_SLVERR;
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // registers, counter and waveform
    always @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg                 <= `TPWM2_RST8;
            timer_control_one_reg    <= `TPWM2_RST8;
            triggered_pwm_mode_control_two_reg     <= `TPWM2_RST8;
            input_filter_select_reg  <= `TPWM2_RST8;
            period_compare_reg       <= `TPWM2_RST16;
            change_point_compare_reg <= `TPWM2_RST16;
            wait_time_compare_reg    <= `TPWM2_RST16;
            next_change_buffer_reg   <= `TPWM2_RST16;
            main_counter_reg         <= `TPWM2_RST16;
            prescale_reg             <= 5'h00;
            ext_clk_prev_reg         <= 1'b0;
            halted_reg               <= 1'b0;
            trig_seen_reg            <= 1'b0;
            trig_prev_reg            <= 1'b0;
            timer_pin_bcd_out        <= 3'h0;
            timer_pin_bcd_oe         <= 3'h0;
        end else begin
            prescale_reg     <= prescale_reg + 5'h01;
            ext_clk_prev_reg <= ext_count_clk;
            trig_prev_reg    <= pin_eff[4];
            main_counter_reg <= cnt_next;
            if (period_hit && stop_eff) begin
                halted_reg    <= 1'b1;
                trig_seen_reg <= 1'b0;
            end else if (trig_edge || !mode_reg[`TPWM2_START_BIT]) begin
                halted_reg    <= 1'b0;
                trig_seen_reg <= trig_edge;
            end
            // buffered change point moves in at period end
            if (period_hit && mode_reg[`TPWM2_BUFD_BIT] && (mode_sel == `TPWM2_MD_TRIGGERED_PWM_MODE))
                change_point_compare_reg <= next_change_buffer_reg;
            if (mode_sel == `TPWM2_MD_TRIGGERED_PWM_MODE) begin
                // only pin b carries the wave; the buffer alone is ignored
                timer_pin_bcd_oe <= 3'h1;
                if (!mode_reg[`TPWM2_START_BIT] || trig_edge)
                    timer_pin_bcd_out[0] <= timer_control_one_reg[`TPWM2_TOB_BIT];
                else if (run && count_tick && (main_counter_reg == change_point_compare_reg))
                    timer_pin_bcd_out[0] <= timer_control_one_reg[`TPWM2_TOB_BIT];
                else if (run && count_tick && (main_counter_reg == wait_time_compare_reg))
                    timer_pin_bcd_out[0] <= !timer_control_one_reg[`TPWM2_TOB_BIT];
                timer_pin_bcd_out[2:1] <= 2'h0;
            end else if (mode_sel == `TPWM2_MD_PWM) begin
                timer_pin_bcd_oe  <= 3'h7;
                // active while below the channel compare, level from polarity
                timer_pin_bcd_out <= ~(triggered_pwm_mode_control_two_reg[`TPWM2_POLARITY_OUT_D_BIT:`TPWM2_POLARITY_OUT_B_BIT] ^
                                     {(main_counter_reg < next_change_buffer_reg),
                                      (main_counter_reg < wait_time_compare_reg),
                                      (main_counter_reg < change_point_compare_reg)});
            end else begin
                timer_pin_bcd_oe  <= 3'h0;
                timer_pin_bcd_out <= 3'h0;
            end
            if (wr_go) begin
                if (aw_idx_reg == `TPWM2_IDX_MODE && w_strb_reg[0])
                    mode_reg <= w_data_reg[7:0];
                else if (aw_idx_reg == `TPWM2_IDX_CTRL1 && w_strb_reg[0])
                    timer_control_one_reg <= w_data_reg[7:0];
                else if (aw_idx_reg == `TPWM2_IDX_CTRL2 && w_strb_reg[0])
                    triggered_pwm_mode_control_two_reg <= {w_data_reg[7:5], 2'h0, w_data_reg[2:0]};
                else if (aw_idx_reg == `TPWM2_IDX_FILT && w_strb_reg[0])
                    input_filter_select_reg <= {w_data_reg[7:6], 1'b0, w_data_reg[4:0]};
                else if (aw_idx_reg == `TPWM2_IDX_PERIOD)
                    period_compare_reg <= lane_merge(period_compare_reg, w_data_reg, w_strb_reg);
                else if (aw_idx_reg == `TPWM2_IDX_CHANGE)
                    change_point_compare_reg <= lane_merge(change_point_compare_reg, w_data_reg, w_strb_reg);
                else if (aw_idx_reg == `TPWM2_IDX_WAIT)
                    wait_time_compare_reg <= lane_merge(wait_time_compare_reg, w_data_reg, w_strb_reg);
                else if (aw_idx_reg == `TPWM2_IDX_NEXT)
                    next_change_buffer_reg <= lane_merge(next_change_buffer_reg, w_data_reg, w_strb_reg);
                else if (aw_idx_reg == `TPWM2_IDX_COUNT)
                    main_counter_reg <= lane_merge(main_counter_reg, w_data_reg, w_strb_reg);
            end
        end
    end
endmodule

// file: tpwm2_defines.vh
// register map, field positions, reset values and codes of the triggered pwm block
// assumes byte address = 4 * register index on a 32-bit axi4-lite bus
`ifndef TPWM2_DEFINES_VH
`define TPWM2_DEFINES_VH
// register indices, byte address is four times the index
`define TPWM2_IDX_MODE      10'h120
`define TPWM2_IDX_CTRL1     10'h121
`define TPWM2_IDX_CTRL2     10'h130
`define TPWM2_IDX_FILT      10'h131
`define TPWM2_IDX_PERIOD    10'h140
`define TPWM2_IDX_CHANGE    10'h141
`define TPWM2_IDX_WAIT      10'h142
`define TPWM2_IDX_NEXT      10'h143
`define TPWM2_IDX_COUNT     10'h144
`define TPWM2_IDX_STATUS    10'h145
// mode register fields
`define TPWM2_MODE_LO       0
`define TPWM2_MODE_HI       1
`define TPWM2_START_BIT     2
`define TPWM2_BUFC_BIT      3
`define TPWM2_BUFD_BIT      4
// timer mode codes
`define TPWM2_MD_COMPARE    2'h0
`define TPWM2_MD_PWM        2'h1
`define TPWM2_MD_TRIGGERED_PWM_MODE       2'h2
`define TPWM2_MD_CAPTURE    2'h3
// control one fields
`define TPWM2_TOB_BIT       1
`define TPWM2_CSRC_LO       4
`define TPWM2_CSRC_HI       6
`define TPWM2_COUNTER_CLEAR_SEL_BIT      7
// control two fields
`define TPWM2_POLARITY_OUT_B_BIT      0
`define TPWM2_POLARITY_OUT_D_BIT      2
`define TPWM2_STOP_ON_PERIOD_MATCH_BIT      5
`define TPWM2_EDGE_LO       6
`define TPWM2_EDGE_HI       7
`define TPWM2_CTRL2_FILL    2'h3
// filter select fields
`define TPWM2_FEN_HI        4
`define TPWM2_FCK_LO        6
`define TPWM2_FCK_HI        7
// trigger edge codes
`define TPWM2_EDGE_OFF      2'h0
`define TPWM2_EDGE_RISE     2'h1
`define TPWM2_EDGE_FALL     2'h2
// filter clock codes
`define TPWM2_FCK_F32       2'h0
`define TPWM2_FCK_F8        2'h1
`define TPWM2_FCK_F1        2'h2
// count source codes
`define TPWM2_CS_F2         3'h1
`define TPWM2_CS_F4         3'h2
`define TPWM2_CS_F8         3'h3
`define TPWM2_CS_F32        3'h4
`define TPWM2_CS_EXT        3'h5
// reset values
`define TPWM2_RST8          8'h00
`define TPWM2_RST16         16'h0000
// filter samples that must agree
`define TPWM2_FILT_LEN      3
// axi responses
`define TPWM2_OKAY          2'h0
`define TPWM2_SLVERR        2'h2
`endif

// file: tpwm2_timer_props.sv
// bus handshake and pin enable checks for the triggered pwm timer
// assumes the port names of tpwm2_timer and one clock domain
`timescale 1ns/100ps
module tpwm2_timer_props (
    // clock and reset
    input wire        aclk,
    input wire        aresetn,
    // register bus
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // pins
    input wire [2:0]  timer_pin_bcd_out,
    input wire [2:0]  timer_pin_bcd_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response changed before accepted");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before accepted");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during answer");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    a_resp_codes: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
        else $error("bad write response code");
    a_pin_enables: assert property (timer_pin_bcd_oe == 3'h0 || timer_pin_bcd_oe == 3'h1 || timer_pin_bcd_oe == 3'h7)
        else $error("pin enable pattern not allowed");
    c_read: cover property (s_axi_arvalid && s_axi_arready);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    c_triggered_pwm_mode_edge: cover property (timer_pin_bcd_oe == 3'h1 && $rose(timer_pin_bcd_out[0]));
endmodule
bind tpwm2_timer tpwm2_timer_props tpwm2_timer_props_inst (.*);

// file: tpwm2_load_model.sv
// trigger source and pwm load on pin b, measures pulse and period widths
// assumes pin b is pulled low while the timer does not drive it
`timescale 1ns/100ps
module tpwm2_load_model (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // trigger
    input  wire        trig_cmd,
    output reg         trig_pin = 1'b0,
    // load
    input  wire [2:0]  pin_out,
    input  wire [2:0]  pin_oe,
    output reg  [15:0] high_len,
    output reg  [15:0] period_len,
    output reg  [15:0] rise_count
);
    reg  [15:0] since_rise_reg;
    reg         b_last_reg;
    wire        b_level = pin_oe[0] ? pin_out[0] : 1'b0;
    always @(posedge aclk) begin
        trig_pin <= trig_cmd;
        if (!aresetn) begin
            since_rise_reg <= 16'h0000;
            b_last_reg <= 1'b0;
            high_len <= 16'h0000;
            period_len <= 16'h0000;
            rise_count <= 16'h0000;
        end else begin
            b_last_reg <= b_level;
            since_rise_reg <= since_rise_reg + 16'h0001;
            if (b_level && !b_last_reg) begin
                period_len <= since_rise_reg;
                since_rise_reg <= 16'h0001;
                rise_count <= rise_count + 16'h0001;
            end
            if (!b_level && b_last_reg)
                high_len <= since_rise_reg;
        end
    end
endmodule

// file: timer_triggered_pwm_mode_trigger_filter_control_bench.sv
// self-checking bench: register readback, triggered_pwm_mode widths, trigger edges, stop
// assumes the timer answers on axi4-lite and pin b drives the load model
`timescale 1ns/100ps
`include "tpwm2_defines.vh"
module timer_triggered_pwm_mode_trigger_filter_control_bench;
    reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg  [11:0] s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata, noise, rnd, rdat, v;
    reg  [3:0]  s_axi_wstrb, timer_pin_in;
    reg  [1:0]  resp;
    reg         ext_count_clk, trig_cmd;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, external_trigger_pin;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0]  timer_pin_bcd_out, timer_pin_bcd_oe;
    wire [15:0] high_len, period_len, rise_count;
    integer     bad_count, total_checks, i, j;
    reg  [15:0] r0;
    localparam [15:0] P = 16'h0028, C = 16'h0014, W = 16'h0008;
    tpwm2_timer tpwm2_timer_inst (.*);
    tpwm2_load_model tpwm2_load_model_inst (.aclk(aclk), .aresetn(aresetn), .trig_cmd(trig_cmd),
        .trig_pin(external_trigger_pin), .pin_out(timer_pin_bcd_out), .pin_oe(timer_pin_bcd_oe),
        .high_len(high_len), .period_len(period_len), .rise_count(rise_count));
    function [31:0] xs(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    task chk(input [8*12-1:0] what, input [31:0] exp, input [31:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[ERR] %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wr(input [9:0] idx, input [31:0] d);
        begin
            @(posedge aclk);
            s_axi_awaddr <= {idx, 2'b00};
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
            end while (s_axi_bvalid !== 1'b1);
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask
    task rd(input [9:0] idx);
        begin
            @(posedge aclk);
            s_axi_araddr <= {idx, 2'b00};
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
            end while (s_axi_rvalid !== 1'b1);
            rdat = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask
    task wait_rises(input integer k);
        begin
            r0 = rise_count;
            while (rise_count < r0 + k)
                @(posedge aclk);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // pins a..d and the external count input see noise throughout
    always @(posedge aclk) begin
        noise <= xs(noise);
        timer_pin_in <= noise[3:0];
        ext_count_clk <= noise[8];
    end
    initial begin
        #300000;
        bad_count = bad_count + 1;
        finish_test;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, trig_cmd} = 7'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rdat} = 88'h0;
        s_axi_wstrb = 4'hF;
        noise = 32'hB6B61F13;
        rnd = 32'hB6B61F13;
        timer_pin_in = 4'h0;
        ext_count_clk = 1'b0;
        bad_count = 0;
        total_checks = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`TPWM2_IDX_CTRL2);
        chk("ctrl2 reset", 32'h18, rdat);
        rd(`TPWM2_IDX_FILT);
        chk("filt reset", 32'h0, rdat);
        for (i = 0; i < 4; i = i + 1) begin
            rnd = xs(rnd);
            wr(`TPWM2_IDX_CTRL2, {24'h0, rnd[7:0] & 8'hE7});
            rd(`TPWM2_IDX_CTRL2);
            chk("ctrl2 rback", {24'h0, rnd[7:0] & 8'hE7 | 8'h18}, rdat);
            v = {24'h0, i[1:0], 1'b0, rnd[12:8]};
            wr(`TPWM2_IDX_FILT, v);
            rd(`TPWM2_IDX_FILT);
            chk("filt rback", v & 32'hDF, rdat);
        end
        rd(10'h3FF);
        chk("unmapped rd", 32'h2, resp);
        wr(10'h3FF, 32'h0);
        chk("unmapped wr", 32'h2, resp);
        $display("test registers done");
        wr(`TPWM2_IDX_FILT, 32'h0);
        wr(`TPWM2_IDX_PERIOD, P);
        wr(`TPWM2_IDX_CHANGE, C);
        wr(`TPWM2_IDX_WAIT, W);
        for (i = 0; i < 2; i = i + 1) begin
            wr(`TPWM2_IDX_MODE, 32'h02);
            wr(`TPWM2_IDX_CTRL1, 32'h80 | (i << 1));
            wr(`TPWM2_IDX_CTRL2, 32'h0);
            wr(`TPWM2_IDX_MODE, 32'h06);
            wait_rises(3);
            chk("triggered_pwm_mode oe", 32'h1, timer_pin_bcd_oe);
            chk("triggered_pwm_mode high", i ? P + 1 - (C - W) : C - W, high_len);
            chk("triggered_pwm_mode period", P + 1, period_len);
            $display("test triggered_pwm_mode level %0d done", i);
        end
        for (j = 0; j < 2; j = j + 1) begin
            wr(`TPWM2_IDX_MODE, 32'h02);
            wr(`TPWM2_IDX_CTRL1, 32'h80);
            wr(`TPWM2_IDX_CTRL2, 32'h40 | j);
            wr(`TPWM2_IDX_MODE, 32'h05);
            wait_rises(3);
            chk("pwm oe", 32'h7, timer_pin_bcd_oe);
            chk("pwm pin d", 32'h1, timer_pin_bcd_out[2]);
            chk("pwm high", j ? C : P + 1 - C, high_len);
            $display("test plain pwm polarity %0d done", j);
        end
        for (i = 1; i < 4; i = i + 1) begin
            for (j = 0; j < 2; j = j + 1) begin
                // leave triggered_pwm_mode so a filter switch makes no false edge
                wr(`TPWM2_IDX_MODE, 32'h00);
                trig_cmd <= j;
                wr(`TPWM2_IDX_FILT, i == 3 ? 32'h90 : 32'h0);
                wr(`TPWM2_IDX_CTRL2, i << 6);
                wr(`TPWM2_IDX_MODE, 32'h06);
                r0 = rise_count;
                repeat (100) @(posedge aclk);
                chk("trig held", r0, rise_count);
                trig_cmd <= !j;
                repeat (100) @(posedge aclk);
                chk("trig fired", j ? i / 2 : i % 2, rise_count != r0);
            end
            $display("test trigger code %0d done", i);
        end
        wr(`TPWM2_IDX_MODE, 32'h02);
        wr(`TPWM2_IDX_CTRL2, 32'h20);
        wr(`TPWM2_IDX_CTRL1, 32'h90);
        wr(`TPWM2_IDX_NEXT, 32'h11);
        wr(`TPWM2_IDX_MODE, 32'h16);
        repeat (200) @(posedge aclk);
        rd(`TPWM2_IDX_STATUS);
        chk("halted", 32'h1, rdat[6]);
        rd(`TPWM2_IDX_CHANGE);
        chk("buffered cp", 32'h11, rdat);
        rd(`TPWM2_IDX_COUNT);
        v = rdat;
        repeat (20) @(posedge aclk);
        rd(`TPWM2_IDX_COUNT);
        chk("count still", v, rdat);
        $display("test stop on period done");
        finish_test;
    end
endmodule
